// [core/hspfc_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - LOCK high only while radio sync with base station is valid
// - Ack line goes low after good radio send, held until RTS inactive
// - Programming port is SPI slave only, used only while in reset
// - RTS, ack and CTS pins become SPI data out, clock in, data in
// - CTS low lets modem send serial data, high stops it
// - RTS low lets host send serial data, high stops it
// - RTS goes inactive on buffer threshold or serial idle time-out
// - NRZ serial, one is high; TXD leaves modem, RXD enters it
// - No serial transmission while CTS is inactive; a character already started still completes
// - Sync, lock, radio send and serial receive run while CTS inactive
// - Radio frames arriving while CTS inactive are dropped, not acked
// - Unacknowledged radio frame reported as lost on the ack line
// - Unused pins are inputs with no effect
// - Buffer threshold up to 130-byte capacity, default 130
// - Serial idle time-out 2 to 100 ms, default 5 ms
// - Speed code 2..6 gives 2400..38400 baud, default 19200

module hspfc_top
    import hspfc_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       RESET_N,
    input  wire logic       RXD,
    input  wire logic       CTS_N,
    input  wire logic       ACK_TX_N_I,
    input  wire logic [3:0] NU_IN,
    input  wire hspfc_cfg_s CFG,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    input  wire logic       RADIO_SYNC_VALID,
    input  wire logic       RADIO_TX_DONE,
    input  wire logic       RADIO_TX_OK,
    input  wire logic       RADIO_FRAME_VALID,
    input  wire logic [7:0] SPI_TX_DATA,
    output var  logic       TXD,
    output var  logic       RTS_N,
    output var  logic       ACK_TX_N_O,
    output var  logic       ACK_TX_N_OE,
    output var  logic       LOCK,
    output var  logic       TX_READY,
    output var  logic [7:0] RX_DATA,
    output var  logic       RX_VALID,
    output var  logic       RX_PERR,
    output var  logic       RADIO_FRAME_ACCEPT,
    output var  logic [7:0] SPI_RX_DATA,
    output var  logic       SPI_RX_VALID,
    output var  logic       PROG_MODE
);
    // Spare pins NU_IN are inputs and are never looked at

    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP}
        hspfc_tx_e;

    logic [3:0]  s1_q;
    logic [3:0]  s2_q;
    logic [3:0]  s3_q;
    logic [3:0]  pin_q;
    logic        prog;
    logic        rst_fn;
    logic        cts_n;
    hspfc_tx_e   tx_st_q;
    logic [15:0] tx_cnt_q;
    logic [15:0] div;
    logic [2:0]  tx_bit_q;
    logic [7:0]  tx_sh_q;
    logic        tx_par_q;
    logic        tx_take;
    logic [7:0]  fill_q;
    logic        rts_n_q;
    logic        rx_hit;
    logic        idle_exp;
    logic        rts_set;
    logic [14:0] ms_pre_q;
    logic [6:0]  ms_q;
    logic        ack_n_q;
    logic        sck_d_q;
    logic        sck_rise;
    logic        sck_fall;
    logic [2:0]  spi_cnt_q;
    logic [7:0]  spi_in_q;
    logic [7:0]  spi_out_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            s1_q  <= PIN_IDLE;
            s2_q  <= PIN_IDLE;
            s3_q  <= PIN_IDLE;
            pin_q <= PIN_IDLE;
        end
        else
        begin
            s1_q <= {RESET_N, ACK_TX_N_I, CTS_N, RXD};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 4; i++)
                if (s2_q[i] == s3_q[i])
                    pin_q[i] <= s3_q[i];
        end
    end

    assign prog   = ~pin_q[PIN_RST];
    assign rst_fn = SRST | prog;
    assign cts_n  = pin_q[PIN_CTS];
    assign div    = baud_div(CFG.serial_speed_code);

    always_ff @(posedge CLK)
    begin
        if (SRST)
            PROG_MODE <= 1'b0;
        else
            PROG_MODE <= prog;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial transmit; config changes mid-character corrupt that word
    assign tx_take = TX_READY & TX_VALID;

    always_ff @(posedge CLK)
    begin
        if (rst_fn)
            TX_READY <= 1'b0;
        else
            TX_READY <= ~cts_n & (tx_st_q == T_IDLE) & ~tx_take;
    end

    always_ff @(posedge CLK)
    begin
        if (rst_fn)
        begin
            tx_st_q  <= T_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 3'h0;
            tx_sh_q  <= 8'h00;
            tx_par_q <= 1'b0;
            TXD      <= 1'b1;
        end
        else if (tx_st_q == T_IDLE)
        begin
            TXD <= 1'b1;
            if (tx_take)
            begin
                tx_sh_q  <= TX_DATA;
                tx_par_q <= parity_of(TX_DATA, CFG);
                TXD      <= 1'b0;
                tx_cnt_q <= div - 16'h0001;
                tx_st_q  <= T_START;
            end
        end
        else if (tx_cnt_q != 16'h0000)
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        else
        begin
            tx_cnt_q <= div - 16'h0001;
            case (tx_st_q)
                T_START:
                begin
                    TXD      <= tx_sh_q[0];
                    tx_sh_q  <= tx_sh_q >> 1;
                    tx_bit_q <= 3'h0;
                    tx_st_q  <= T_DATA;
                end
                T_DATA:
                begin
                    tx_bit_q <= tx_bit_q + 3'h1;
                    if (tx_bit_q != last_bit(CFG))
                    begin
                        TXD     <= tx_sh_q[0];
                        tx_sh_q <= tx_sh_q >> 1;
                    end
                    else if (has_par(CFG))
                    begin
                        TXD     <= tx_par_q;
                        tx_st_q <= T_PAR;
                    end
                    else
                    begin
                        TXD     <= 1'b1;
                        tx_st_q <= T_STOP;
                    end
                end
                T_PAR:
                begin
                    TXD     <= 1'b1;
                    tx_st_q <= T_STOP;
                end
                default:
                    tx_st_q <= T_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial receive keeps running whatever CTS does
    hspfc_uart_rx u_rx
    (
        .clk     (CLK),
        .srst    (rst_fn),
        .rxd     (pin_q[PIN_RXD]),
        .cfg     (CFG),
        .data_q  (RX_DATA),
        .valid_q (RX_VALID),
        .perr_q  (RX_PERR)
    );

    ////////////////////////////////////////////////////////////////////////
    // Buffer fill, idle timer and send permission
    assign rx_hit   = RX_VALID && ({1'b0, fill_q} + 9'h001
                    >= {1'b0, clamp_thr(CFG.rx_buffer_threshold)});
    assign idle_exp = (fill_q != 8'h00) && !rts_n_q
                    && (ms_q >= clamp_idle(CFG.serial_idle_timeout));
    assign rts_set  = !rts_n_q && (rx_hit || idle_exp) && !RADIO_TX_DONE;

    // A finished radio send empties the buffer, except for a word received in that cycle
    always_ff @(posedge CLK)
    begin
        if (rst_fn)
            fill_q <= 8'h00;
        else if (RADIO_TX_DONE)
            fill_q <= RX_VALID ? 8'h01 : 8'h00;
        else if (RX_VALID && fill_q != BUF_CAP)
            fill_q <= fill_q + 8'h01;
    end

    always_ff @(posedge CLK)
    begin
        if (rst_fn)
            rts_n_q <= 1'b0;
        else if (RADIO_TX_DONE)
            rts_n_q <= 1'b0;
        else if (rts_set)
            rts_n_q <= 1'b1;
    end

    // Idle time counts from the last received word
    always_ff @(posedge CLK)
    begin
        if (rst_fn || RX_VALID)
        begin
            ms_pre_q <= 15'h0000;
            ms_q     <= 7'h00;
        end
        else if (ms_pre_q == MS_PRE_LAST)
        begin
            ms_pre_q <= 15'h0000;
            if (ms_q != IDLE_SAT)
                ms_q <= ms_q + 7'h01;
        end
        else
            ms_pre_q <= ms_pre_q + 15'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Ack line: a good send sets it over a clear in the same cycle
    always_ff @(posedge CLK)
    begin
        if (rst_fn)
            ack_n_q <= 1'b1;
        else if (RADIO_TX_DONE)
            ack_n_q <= ~RADIO_TX_OK;
        else if (rts_set)
            ack_n_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Radio side status; none of it depends on CTS except frame intake
    always_ff @(posedge CLK)
    begin
        if (rst_fn)
        begin
            LOCK               <= 1'b0;
            RADIO_FRAME_ACCEPT <= 1'b0;
        end
        else
        begin
            LOCK               <= RADIO_SYNC_VALID;
            RADIO_FRAME_ACCEPT <= RADIO_FRAME_VALID & ~cts_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming slave, mode 0; SCK must stay well below CLK/8
    assign sck_rise = pin_q[PIN_SCK] & ~sck_d_q;
    assign sck_fall = ~pin_q[PIN_SCK] & sck_d_q;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sck_d_q      <= 1'b1;
            spi_cnt_q    <= 3'h0;
            spi_in_q     <= 8'h00;
            spi_out_q    <= 8'h00;
            SPI_RX_DATA  <= 8'h00;
            SPI_RX_VALID <= 1'b0;
        end
        else
        begin
            sck_d_q      <= pin_q[PIN_SCK];
            SPI_RX_VALID <= 1'b0;
            if (!prog)
            begin
                spi_cnt_q <= 3'h0;
                spi_out_q <= SPI_TX_DATA;
            end
            else if (sck_rise)
            begin
                spi_in_q  <= {spi_in_q[6:0], pin_q[PIN_CTS]};
                spi_cnt_q <= spi_cnt_q + 3'h1;
                if (spi_cnt_q == 3'h7)
                begin
                    SPI_RX_DATA  <= {spi_in_q[6:0], pin_q[PIN_CTS]};
                    SPI_RX_VALID <= 1'b1;
                end
            end
            else if (sck_fall)
                spi_out_q <= (spi_cnt_q == 3'h0) ? SPI_TX_DATA
                           : {spi_out_q[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared pins: flow control in service, SPI while held in reset
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            RTS_N       <= 1'b0;
            ACK_TX_N_O  <= 1'b1;
            ACK_TX_N_OE <= 1'b1;
        end
        else
        begin
            RTS_N       <= prog ? spi_out_q[7] : rts_n_q;
            ACK_TX_N_O  <= ack_n_q;
            ACK_TX_N_OE <= ~prog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    sequence s_tx_take;
        tx_take && !prog;
    endsequence

    sequence s_lost;
        RADIO_TX_DONE && !RADIO_TX_OK && !prog;
    endsequence

    a_lock_valid: assert property (!RADIO_SYNC_VALID |=> !LOCK)
        else $error("lock high without sync");
    a_lock_runs: assert property (
        (RADIO_SYNC_VALID && !prog && cts_n) |=> LOCK)
        else $error("lock dropped while CTS inactive");
    a_ack_hold: assert property (
        (!ack_n_q && !rts_set && !RADIO_TX_DONE && !prog) |=> !ack_n_q)
        else $error("ack released before RTS inactive");
    a_ack_lost: assert property (s_lost |=> ack_n_q ##1 ACK_TX_N_O)
        else $error("lost frame shown as acknowledged");
    a_rts_fill: assert property (
        (rx_hit && !rts_n_q && !RADIO_TX_DONE && !prog)
        |=> rts_n_q ##1 RTS_N)
        else $error("RTS not raised at threshold");
    a_tx_hold: assert property (
        ($past(cts_n) && tx_st_q == T_IDLE) |=> tx_st_q == T_IDLE)
        else $error("serial send started with CTS inactive");
    a_frame_drop: assert property (
        (RADIO_FRAME_VALID && cts_n) |=> !RADIO_FRAME_ACCEPT)
        else $error("frame accepted with CTS inactive");
    a_tx_start: assert property (s_tx_take |=> !TXD [*8])
        else $error("start bit missing");
    a_spi_pin: assert property (prog |=> !ACK_TX_N_OE)
        else $error("ack pin driven during programming");

endmodule

`default_nettype wire

// [core/hspfc_uart_rx.sv]
`timescale 1ns/1ps
`default_nettype none

module hspfc_uart_rx
    import hspfc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       rxd,
    input  wire hspfc_cfg_s cfg,
    output var  logic [7:0] data_q,
    output var  logic       valid_q,
    output var  logic       perr_q
);

    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP}
        hspfc_rx_e;

    hspfc_rx_e   st_q;
    logic [15:0] cnt_q;
    logic [15:0] div;
    logic [2:0]  bit_q;
    logic [7:0]  sh_q;
    logic [7:0]  word;
    logic        par_q;

    assign div  = baud_div(cfg.serial_speed_code);
    // Seven-bit words end up one place high in the shifter
    assign word = cfg.data7 ? {1'b0, sh_q[7:1]} : sh_q;

    ////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling; a start glitch shorter than half a bit is dropped
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q  <= R_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
            par_q <= 1'b0;
        end
        else if (st_q == R_IDLE)
        begin
            if (!rxd)
            begin
                st_q  <= R_START;
                cnt_q <= div >> 1;
            end
        end
        else if (cnt_q != 16'h0000)
            cnt_q <= cnt_q - 16'h0001;
        else
        begin
            cnt_q <= div - 16'h0001;
            case (st_q)
                R_START:
                begin
                    st_q  <= rxd ? R_IDLE : R_DATA;
                    bit_q <= 3'h0;
                end
                R_DATA:
                begin
                    sh_q  <= {rxd, sh_q[7:1]};
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == last_bit(cfg))
                        st_q <= has_par(cfg) ? R_PAR : R_STOP;
                end
                R_PAR:
                begin
                    par_q <= rxd;
                    st_q  <= R_STOP;
                end
                default:
                    st_q <= R_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word out at mid stop bit; bad stop or parity flags an error
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            data_q  <= 8'h00;
            valid_q <= 1'b0;
            perr_q  <= 1'b0;
        end
        else
        begin
            valid_q <= 1'b0;
            perr_q  <= 1'b0;
            if (st_q == R_STOP && cnt_q == 16'h0000)
            begin
                data_q  <= word;
                valid_q <= 1'b1;
                perr_q  <= !rxd
                        || (has_par(cfg) && par_q != parity_of(word, cfg));
            end
        end
    end

endmodule

`default_nettype wire

// [include/hspfc_pkg.sv]
package hspfc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and time bases
    localparam int              CLK_HZ      = 25_000_000;
    localparam int              MS_PER_S    = 1000;
    localparam int              CYC_PER_MS  = CLK_HZ / MS_PER_S;
    localparam logic [14:0]     MS_PRE_LAST = 15'(CYC_PER_MS - 1);
    localparam int              RST_MAX_MS  = 200;

    ////////////////////////////////////////////////////////////////////////
    // Serial link settings
    localparam int              BASE_BAUD   = 2400;
    localparam logic [2:0]      SPEED_MIN   = 3'h2;
    localparam logic [2:0]      SPEED_MAX   = 3'h6;
    localparam logic [2:0]      SPEED_DEF   = 3'h5;
    localparam logic [6:0]      IDLE_MIN_MS = 7'h02;
    localparam logic [6:0]      IDLE_MAX_MS = 7'h64;
    localparam logic [6:0]      IDLE_DEF_MS = 7'h05;
    localparam logic [6:0]      IDLE_SAT    = 7'h7f;
    localparam logic [7:0]      BUF_CAP     = 8'h82;
    localparam logic [1:0]      PAR_NONE    = 2'h1;
    localparam logic [1:0]      PAR_EVEN    = 2'h2;
    localparam logic [1:0]      PAR_ODD     = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Pin vector positions after synchronisation
    localparam int              PIN_RXD     = 0;
    localparam int              PIN_CTS     = 1;
    localparam int              PIN_SCK     = 2;
    localparam int              PIN_RST     = 3;
    localparam logic [3:0]      PIN_IDLE    = 4'hf;

    typedef struct packed {
        logic [2:0] serial_speed_code;
        logic [6:0] serial_idle_timeout;
        logic [7:0] rx_buffer_threshold;
        logic       data7;
        logic [1:0] parity;
    } hspfc_cfg_s;

    function automatic logic [15:0] baud_div(input logic [2:0] code);
        int sh;
        sh = (code < SPEED_MIN || code > SPEED_MAX)
           ? int'(SPEED_DEF - SPEED_MIN) : int'(code - SPEED_MIN);
        return 16'(CLK_HZ / (BASE_BAUD << sh));
    endfunction

    function automatic logic [6:0] clamp_idle(input logic [6:0] ms);
        if (ms < IDLE_MIN_MS)
            return IDLE_MIN_MS;
        if (ms > IDLE_MAX_MS)
            return IDLE_MAX_MS;
        return ms;
    endfunction

    function automatic logic [7:0] clamp_thr(input logic [7:0] t);
        if (t == 8'h00)
            return 8'h01;
        if (t > BUF_CAP)
            return BUF_CAP;
        return t;
    endfunction

    function automatic logic has_par(input hspfc_cfg_s c);
        return (c.parity == PAR_EVEN) || (c.parity == PAR_ODD);
    endfunction

    function automatic logic parity_of(input logic [7:0] d,
                                       input hspfc_cfg_s c);
        logic p;
        p = c.data7 ? ^d[6:0] : ^d;
        return (c.parity == PAR_ODD) ? ~p : p;
    endfunction

    function automatic logic [2:0] last_bit(input hspfc_cfg_s c);
        return c.data7 ? 3'h6 : 3'h7;
    endfunction

endpackage

// [verif/host_serial_port_flow_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module host_serial_port_flow_control_bench
    import hspfc_pkg::*;
;
    localparam int DIV = CLK_HZ / (BASE_BAUD << 4);
    typedef struct packed {
        logic [7:0] tx;
        logic [7:0] rx;
        logic       par;
        logic       d7;
        logic [1:0] pcode;
        logic [7:0] host_exp;
        logic [7:0] rx_exp;
    } hspfc_row_s;

    // A 7-bit word with parity travels like a plain 8-bit frame
    hspfc_row_s rows [3] = '{
        {8'ha5, 8'h3c, 1'b0, 1'b0, PAR_NONE, 8'ha5, 8'h3c},
        {8'h35, 8'hcb, 1'b0, 1'b1, PAR_ODD, 8'hb5, 8'h4b},
        {8'h01, 8'hfe, 1'b1, 1'b0, PAR_EVEN, 8'h01, 8'hfe}};
    logic       clk, srst, reset_n, cts_n, tx_valid, sync, done, ok;
    logic       fvalid, sck, par_on, rxd, ack_wire;
    logic       txd, rts_n, ack_o, ack_oe, lock, tx_ready, rx_valid;
    logic       rx_perr, faccept, spi_valid, prog;
    logic [7:0] tx_data, spi_tx, rx_data, spi_rx, spi_got, miso;
    logic [3:0] nu;
    hspfc_cfg_s cfg;
    int         comparisons = 0;
    int         miscompares = 0;
    int         rx_hits = 0;
    logic       perr_seen = 1'b1;
    int         cyc = 0;

    // Ack pin is shared: design drives it unless programming
    assign ack_wire = ack_oe ? ack_o : sck;

    hspfc_top uut (.CLK(clk), .SRST(srst), .RESET_N(reset_n), .RXD(rxd),
        .CTS_N(cts_n), .ACK_TX_N_I(ack_wire), .NU_IN(nu), .CFG(cfg),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .RADIO_SYNC_VALID(sync),
        .RADIO_TX_DONE(done), .RADIO_TX_OK(ok), .RADIO_FRAME_VALID(fvalid),
        .SPI_TX_DATA(spi_tx), .TXD(txd), .RTS_N(rts_n), .ACK_TX_N_O(ack_o),
        .ACK_TX_N_OE(ack_oe), .LOCK(lock), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_PERR(rx_perr),
        .RADIO_FRAME_ACCEPT(faccept), .SPI_RX_DATA(spi_rx),
        .SPI_RX_VALID(spi_valid), .PROG_MODE(prog));

    hspfc_host_model #(.DIV(DIV)) host (.clk(clk), .txd(txd),
        .rts_n(rts_n), .par_on(par_on), .rxd(rxd));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("counts: %0d comparisons, %0d miscompares",
                 comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Pulses are caught here so no scenario misses one
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1)
        begin
            rx_hits <= rx_hits + 1;
            perr_seen <= rx_perr;
        end
        if (spi_valid === 1'b1)
            spi_got <= spi_rx;
        if (cyc == 95000)
        begin
            miscompares++;
            give_verdict;
        end
    end

    task automatic wait_rx(input int tgt);
        for (int i = 0; i < 20000 && rx_hits < tgt; i++)
            @(posedge clk);
        #1;
    endtask

    // Valid is raised only once ready is seen, so it is taken next edge
    task automatic send_tx(input logic [7:0] b);
        for (int i = 0; i < 20000 && tx_ready !== 1'b1; i++)
            tick(1);
        @(posedge clk);
        tx_data <= b;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    task automatic radio_done(input logic okv);
        @(posedge clk);
        done <= 1'b1;
        ok <= okv;
        @(posedge clk);
        done <= 1'b0;
        tick(3);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] din;
        int         n;
        din = 8'h5a;
        srst = 1'b1;
        reset_n = 1'b1;
        cts_n = 1'b0;
        {tx_valid, sync, done, ok, fvalid, sck, par_on} = 7'h00;
        {tx_data, spi_tx, nu} = 20'h00000;
        cfg = '{3'h6, 7'h02, 8'h82, 1'b0, PAR_NONE};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        nu <= 4'ha;
        tick(8);
        foreach (rows[i])
        begin
            @(posedge clk);
            cfg.parity <= rows[i].pcode;
            cfg.data7 <= rows[i].d7;
            par_on <= rows[i].par;
            // Host reads par_on at once, so let the update land first
            @(posedge clk);
            n = host.got_cnt;
            fork
                host.send_byte(rows[i].rx);
                send_tx(rows[i].tx);
            join
            wait_rx(i + 1);
            for (int k = 0; k < 2000 && host.got_cnt == n; k++)
                @(posedge clk);
            check("host byte", host.got_byte, rows[i].host_exp);
            check("rx data", rx_data, rows[i].rx_exp);
            check("rx error", perr_seen, 1'b0);
            $display("test row %0d done", i);
        end
        // Host falls silent; 2 ms later send permission closes
        check("rts open", rts_n, 1'b0);
        tick(50100);
        check("rts idle", rts_n, 1'b1);
        $display("test idle done");
        // Radio status, then the host refusing serial data
        @(posedge clk);
        sync <= 1'b1;
        fvalid <= 1'b1;
        tick(2);
        check("lock", lock, 1'b1);
        check("accept", faccept, 1'b1);
        @(posedge clk);
        cts_n <= 1'b1;
        tick(8);
        check("accept off", faccept, 1'b0);
        check("lock kept", lock, 1'b1);
        check("tx ready", tx_ready, 1'b0);
        @(posedge clk);
        sync <= 1'b0;
        fvalid <= 1'b0;
        tick(2);
        check("lock off", lock, 1'b0);
        $display("test radio status done");
        // Ack and send permission around a full buffer
        radio_done(1'b1);
        check("rts free", rts_n, 1'b0);
        check("ack ok", ack_o, 1'b0);
        @(posedge clk);
        cfg.rx_buffer_threshold <= 8'h01;
        tick(200);
        check("ack held", ack_o, 1'b0);
        host.send_byte(8'h96);
        wait_rx(4);
        tick(2);
        check("rts full", rts_n, 1'b1);
        check("ack end", ack_o, 1'b1);
        check("rx under cts", rx_data, 8'h96);
        check("txd quiet", txd, 1'b1);
        radio_done(1'b0);
        check("rts lost", rts_n, 1'b0);
        radio_done(1'b1);
        check("ack again", ack_o, 1'b0);
        radio_done(1'b0);
        check("ack lost", ack_o, 1'b1);
        check("host errors", 8'(host.host_err), 8'h00);
        $display("test flow control done");
        // Programming port, short reset pulse well inside the limit
        @(posedge clk);
        spi_tx <= 8'hc3;
        cts_n <= 1'b0;
        reset_n <= 1'b0;
        tick(8);
        check("prog", prog, 1'b1);
        check("ack oe", ack_oe, 1'b0);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge clk);
            cts_n <= din[i];
            tick(10);
            miso[i] = rts_n;
            @(posedge clk);
            sck <= 1'b1;
            tick(10);
            @(posedge clk);
            sck <= 1'b0;
        end
        tick(12);
        check("spi in", spi_got, 8'h5a);
        check("spi out", miso, 8'hc3);
        @(posedge clk);
        cts_n <= 1'b0;
        reset_n <= 1'b1;
        tick(10);
        check("prog off", prog, 1'b0);
        $display("test programming done");
        // Reset in mid run
        @(posedge clk);
        srst <= 1'b1;
        tick(4);
        check("reset txd", txd, 1'b1);
        check("reset rts", rts_n, 1'b0);
        check("reset ack", {ack_o, ack_oe}, 2'h3);
        check("reset lock", lock, 1'b0);
        check("reset ready", tx_ready, 1'b0);
        @(posedge clk);
        srst <= 1'b0;
        tick(8);
        check("ready again", tx_ready, 1'b1);
        check("rts again", rts_n, 1'b0);
        $display("test reset done");
        give_verdict;
    end
endmodule

`default_nettype wire

// [verif/hspfc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module hspfc_host_model
    import hspfc_pkg::*;
#(
    parameter int DIV = 651
)
(
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic rts_n,
    input  wire logic par_on,
    output var  logic rxd
);
    logic [7:0] got_byte = 8'h00;
    int         got_cnt  = 0;
    int         host_err = 0;

    ////////////////////////////////////////////////////////////////////////
    // Host transmit; sending without send permission counts a host error
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] bits;
        int          n;
        if (rts_n !== 1'b0)
            host_err++;
        bits = {1'b1, ^b, b, 1'b0};
        n = par_on ? 11 : 10;
        if (!par_on)
            bits[9] = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            rxd <= bits[i];
            repeat (DIV - 1) @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Host receive, sampled at mid bit
    always
    begin
        logic [10:0] f;
        int          n;
        @(negedge txd);
        n = par_on ? 11 : 10;
        repeat (DIV / 2) @(posedge clk);
        f[0] = txd;
        for (int i = 1; i < n; i++)
        begin
            repeat (DIV) @(posedge clk);
            f[i] = txd;
        end
        if (f[0] !== 1'b0 || f[n-1] !== 1'b1)
            host_err++;
        if (par_on && f[9] !== ^f[8:1])
            host_err++;
        got_byte = f[8:1];
        got_cnt++;
    end

    initial
    begin
        rxd = 1'b1;
    end
endmodule

`default_nettype wire
